// File: design/pnb_device.sv
// Flash device end: pin decode, command state and a small array
`timescale 1ns/1ps
`include "pnb_defines.svh"
module pnb_device
  import pnb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  pnb_if.dev bus,
  input wire logic i_double_density, // Strap: two dies present
  output logic o_busy, // Program or erase automation running
  output logic [15:0] o_status // Status word seen by reads
);
  // ========================================================
  // State
  typedef struct packed {
    pnb_mode_type mode;
    logic [15:0] cfg; // Read configuration
    logic [15:0] status;
    logic [`PNB_ADDR_HI:`PNB_ADDR_LO] addr_lat;
    logic adv_q; // Previous strobe level
    logic clk_q; // Previous read clock level
    logic we_q; // Previous write strobe level
    logic ce_q; // Previous select level
    logic [3:0] lat_cnt; // Sync latency countdown
    logic [15:0] dout;
    logic [15:0] lockdown; // One lock-down bit per block
    logic [15:0] locked; // One lock bit per block
    logic [2:0] busy_cnt;
  } pnb_dev_type;
  pnb_dev_type r;
  pnb_dev_type next_r;
  logic [15:0] mem [0:`PNB_MEM_WORDS-1]; // Small array model
  logic sync_mode;
  logic active;
  logic [`PNB_ADDR_HI:`PNB_ADDR_LO] cur_addr;
  logic write_edge;
  logic [15:0] wdata;
  logic [`PNB_ADDR_HI:`PNB_ADDR_LO] waddr;
  logic [3:0] blk;
  logic mem_we;
  logic [`PNB_MEM_AW-1:0] widx;

  // Active only with select low and reset high
  assign active = ~bus.select_n & bus.reset_n;
  assign sync_mode = ~r.cfg[`PNB_CFG_SYNC_N_BIT];
  assign o_busy = (r.busy_cnt != 3'h0);
  assign o_status = r.status;
  // Flow-through while strobe low in async mode
  assign cur_addr = (!bus.address_latch_strobe_n && !sync_mode)
                    ? bus.addr : r.addr_lat;
  // Write capture on the first rising of strobe or select
  assign write_edge = r.ce_q == 1'b0 && r.we_q == 1'b0 &&
                      (bus.write_n || bus.select_n) &&
                      bus.reset_n;
  assign wdata = bus.dq_host;
  assign waddr = cur_addr;
  assign blk = waddr[`PNB_MEM_AW+4:`PNB_MEM_AW+1];
  assign widx = waddr[`PNB_MEM_AW:1];

  // ========================================================
  // Next state
  always_comb
  begin
    next_r = r;
    mem_we = 1'b0;
    next_r.adv_q = bus.address_latch_strobe_n;
    next_r.clk_q = bus.read_clk;
    next_r.we_q = bus.write_n;
    next_r.ce_q = bus.select_n;
    // Address latch
    if (active && bus.address_latch_strobe_n && !r.adv_q)
    begin
      next_r.addr_lat = bus.addr;
      next_r.lat_cnt = `PNB_LATENCY;
    end
    else if (active && !bus.address_latch_strobe_n)
    begin
      if (!sync_mode)
        next_r.addr_lat = bus.addr;
      else if (bus.read_clk && !r.clk_q)
      begin
        next_r.addr_lat = bus.addr;
        next_r.lat_cnt = `PNB_LATENCY;
      end
    end
    else if (sync_mode && bus.read_clk && !r.clk_q &&
             r.lat_cnt != 4'h0)
      next_r.lat_cnt = r.lat_cnt - 4'h1;
    // Automation timer
    if (r.busy_cnt != 3'h0)
    begin
      next_r.busy_cnt = r.busy_cnt - 3'h1;
      if (r.busy_cnt == 3'h1)
        next_r.status = r.status | `PNB_STATUS_READY;
    end
    // Read data mux
    case (r.mode)
      PNB_RD_STATUS: next_r.dout = r.status;
      PNB_RD_CFG: next_r.dout = r.cfg;
      default: next_r.dout = mem[cur_addr[`PNB_MEM_AW:1]];
    endcase
    // Command decode
    if (write_edge)
    begin
      case (r.mode)
        PNB_WAIT_PROG, PNB_WAIT_ERASE:
        begin
          next_r.mode = PNB_RD_STATUS;
          if (bus.program_lockout_level)
            next_r.status = r.status | `PNB_STATUS_VPP_ERR;
          else if (r.locked[blk] ||
                   (r.mode == PNB_WAIT_ERASE &&
                    wdata != `PNB_CMD_CONFIRM))
            next_r.status = r.status | `PNB_STATUS_LOCK_ERR;
          else
          begin
            mem_we = 1'b1;
            next_r.busy_cnt = 3'h4;
            next_r.status = r.status & ~`PNB_STATUS_READY;
          end
        end
        // Configure and lock share one prefix; the second word picks
        PNB_WAIT_CFG, PNB_WAIT_LOCK:
        begin
          next_r.mode = PNB_RD_ARRAY;
          if (wdata == `PNB_CMD_CFG_CONFIRM)
            next_r.cfg = 16'(waddr[16:1]);
          else if (wdata == `PNB_CMD_LOCKDOWN)
            next_r.lockdown[blk] = 1'b1;
          else if (wdata == `PNB_CMD_CONFIRM)
          begin
            // Lock-down holds only while protect is low
            if (!r.lockdown[blk] || bus.protect_n)
              next_r.locked[blk] = 1'b0;
          end
          else
            next_r.locked[blk] = 1'b1;
        end
        default:
        begin
          case (wdata)
            `PNB_CMD_READ_STATUS: next_r.mode = PNB_RD_STATUS;
            `PNB_CMD_PROGRAM: next_r.mode = PNB_WAIT_PROG;
            `PNB_CMD_ERASE_SETUP: next_r.mode = PNB_WAIT_ERASE;
            `PNB_CMD_CFG_SETUP: next_r.mode = PNB_WAIT_CFG;
            `PNB_CMD_CLEAR_STATUS:
              next_r.status = `PNB_STATUS_READY;
            `PNB_CMD_READ_ARRAY: next_r.mode = PNB_RD_ARRAY;
            default: next_r.mode = PNB_RD_CFG;
          endcase
        end
      endcase
    end
    // Reset pin: automation stopped, async array read
    if (!bus.reset_n)
    begin
      next_r.mode = PNB_RD_ARRAY;
      next_r.cfg = `PNB_CFG_RESET;
      next_r.busy_cnt = 3'h0;
      next_r.status = `PNB_STATUS_READY;
    end
  end

  // ========================================================
  // Registers; array write is a separate memory port
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.cfg <= `PNB_CFG_RESET;
      r.status <= `PNB_STATUS_READY;
      r.adv_q <= 1'b1;
      r.we_q <= 1'b1;
      r.ce_q <= 1'b1;
      r.locked <= 16'hffff;
    end
    else
      r <= next_r;
  end

  always_ff @(posedge i_mclk)
  begin
    // Erase fills every word: the small array stands for one block
    // shared by all block numbers, so a partial fill leaves unknowns
    if (mem_we && !i_rst && r.mode == PNB_WAIT_ERASE)
    begin
      for (int k = 0; k < `PNB_MEM_WORDS; k++)
        mem[k] <= 16'hffff;
    end
    else if (mem_we && !i_rst)
      mem[widx] <= mem[widx] & wdata; // Only clears bits
  end

  // ========================================================
  // Pin drive
  logic rd_en;
  logic die_ok;
  logic wait_act;
  // Upper die bit only decodes when two dies are strapped; this model
  // stands for the lower die, so a high bit there leaves the bus floating
  assign die_ok = !i_double_density || !cur_addr[`PNB_ADDR_HI];
  assign rd_en = active && !bus.out_en_n && bus.write_n
                 && die_ok;
  assign wait_act = sync_mode && (r.lat_cnt != 4'h0);
  always_comb
  begin
    bus.dq_dev = r.dout;
    bus.dq_dev_oe = rd_en;
    bus.wait_oe = rd_en;
    // Polarity bit set means asserted-high
    bus.wait_out = r.cfg[`PNB_CFG_WAIT_POL_BIT] ? wait_act
                   : ~wait_act;
  end
endmodule

// File: inc/pnb_defines.svh
// Constants shared by both ends of the parallel flash bus
// How it works
// - Sync mode: latch address on strobe rise/clock
// - Async mode: latch on strobe rise, else flow
// - Host not using strobe holds it low
// - Select low activates the die logic
// - Select high: standby, data and wait floated
// - Host drives select high when idle
// - Unused read clock held at constant level
// - Output enable low drives data; high floats
// - Reset clears automation, ignores all writes
// - Reset exit returns to async array read
// - Protect low keeps lock-down blocks locked
// - Protect high overrides lock-down
// - Write latched on first select/strobe rise
// - Program supply lockout blocks program/erase
// - Sixteen-bit data both directions
// - Data floats unless selected and enabled
// - Word address, lowest bit is one
// - Die select bit decodes only double density
// - Wait polarity follows config bit
// - Wait asserted while sync data invalid
// - Default async, sync after config set
`ifndef PNB_DEFINES_SVH
`define PNB_DEFINES_SVH
// ==========================================================
// Widths
`define PNB_DATA_W 16
`define PNB_ADDR_HI 25
`define PNB_ADDR_LO 1
// ==========================================================
// Command codes and config fields
`define PNB_CMD_READ_ARRAY 16'h00ff
`define PNB_CMD_READ_STATUS 16'h0070
`define PNB_CMD_CLEAR_STATUS 16'h0050
`define PNB_CMD_PROGRAM 16'h0040
`define PNB_CMD_ERASE_SETUP 16'h0020
`define PNB_CMD_CONFIRM 16'h00d0
`define PNB_CMD_CFG_SETUP 16'h0060
`define PNB_CMD_CFG_CONFIRM 16'h0003
`define PNB_CMD_LOCKDOWN 16'h002f
`define PNB_CFG_SYNC_N_BIT 15
`define PNB_CFG_WAIT_POL_BIT 10
`define PNB_CFG_RESET 16'hbfcf
`define PNB_LATENCY 4'h3
`define PNB_STATUS_READY 16'h0080
`define PNB_STATUS_VPP_ERR 16'h0008
`define PNB_STATUS_LOCK_ERR 16'h0002
`define PNB_MEM_WORDS 256
`define PNB_MEM_AW 8
`endif

// File: inc/pnb_pkg.sv
// Types shared by both ends of the parallel flash bus
package pnb_pkg;
  // Device command state
  typedef enum logic [2:0] {
    PNB_RD_ARRAY, PNB_RD_STATUS, PNB_RD_CFG, PNB_WAIT_PROG,
    PNB_WAIT_ERASE, PNB_WAIT_CFG, PNB_WAIT_LOCK
  } pnb_mode_type;
  // Host access phase
  typedef enum logic [2:0] {
    PNB_H_IDLE, PNB_H_ADDR, PNB_H_RD, PNB_H_WR, PNB_H_END
  } pnb_hstate_type;
endpackage

// File: inc/pnb_if.sv
// Pin bundle joining the flash host and the flash device
`timescale 1ns/1ps
`include "pnb_defines.svh"
interface pnb_if;
  logic [`PNB_ADDR_HI:`PNB_ADDR_LO] addr; // Word address
  logic address_latch_strobe_n;
  logic select_n;
  logic out_en_n;
  logic write_n;
  logic reset_n;
  logic protect_n;
  logic read_clk;
  logic program_lockout_level; // High: supply below lockout
  logic [`PNB_DATA_W-1:0] dq_host; // Host drive value
  logic dq_host_oe;
  logic [`PNB_DATA_W-1:0] dq_dev; // Device drive value
  logic dq_dev_oe;
  logic wait_out;
  logic wait_oe;
  // Host end
  modport host (
    output addr, address_latch_strobe_n, select_n, out_en_n, write_n,
    output reset_n, protect_n, read_clk, program_lockout_level,
    output dq_host, dq_host_oe,
    input dq_dev, dq_dev_oe, wait_out, wait_oe
  );
  // Device end
  modport dev (
    input addr, address_latch_strobe_n, select_n, out_en_n, write_n,
    input reset_n, protect_n, read_clk, program_lockout_level,
    input dq_host, dq_host_oe,
    output dq_dev, dq_dev_oe, wait_out, wait_oe
  );
endinterface

// File: design/pnb_host.sv
// Flash host end: turns user requests into pin cycles
`timescale 1ns/1ps
`include "pnb_defines.svh"
module pnb_host
  import pnb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  pnb_if.host bus,
  input wire logic i_req, // Start an access
  input wire logic i_wr, // 1 write, 0 read
  input wire logic [`PNB_ADDR_HI:`PNB_ADDR_LO] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_protect_n, // Level for the protect pin
  input wire logic i_lockout, // Program supply below lockout
  output logic o_ready, // Can take a request
  output logic o_done, // One-cycle pulse at end
  output logic [15:0] o_rdata
);
  // ========================================================
  // State
  typedef struct packed {
    pnb_hstate_type st;
    logic wr;
    logic [`PNB_ADDR_HI:`PNB_ADDR_LO] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic rst_n; // Reset pin level
  } pnb_host_type;
  pnb_host_type r;
  pnb_host_type next_r;

  // ========================================================
  // Sequencer: addr phase, data phase, recovery
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.rst_n = 1'b1;
    case (r.st)
      PNB_H_IDLE:
        if (i_req)
        begin
          next_r.st = PNB_H_ADDR;
          next_r.wr = i_wr;
          next_r.addr = i_addr;
          next_r.wdata = i_wdata;
        end
      PNB_H_ADDR: next_r.st = r.wr ? PNB_H_WR : PNB_H_RD;
      PNB_H_RD:
      begin
        // A floating bus reads as its pull-up level
        next_r.rdata = bus.dq_dev_oe ? bus.dq_dev : 16'hffff;
        next_r.st = PNB_H_END;
      end
      PNB_H_WR: next_r.st = PNB_H_END;
      PNB_H_END:
      begin
        next_r.done = 1'b1;
        next_r.st = PNB_H_IDLE;
      end
      default: next_r.st = PNB_H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.st <= PNB_H_IDLE;
    end
    else
      r <= next_r;
  end

  // ========================================================
  // Pins
  always_comb
  begin
    bus.addr = r.addr;
    bus.address_latch_strobe_n = 1'b0;
    bus.read_clk = 1'b0;
    bus.select_n = (r.st == PNB_H_IDLE);
    // Read and write strobes never overlap
    bus.out_en_n = !(r.st == PNB_H_RD);
    bus.write_n = !(r.st == PNB_H_WR && r.wr);
    bus.reset_n = r.rst_n;
    bus.protect_n = i_protect_n;
    bus.program_lockout_level = i_lockout;
    bus.dq_host = r.wdata;
    bus.dq_host_oe = r.wr && (r.st != PNB_H_IDLE);
  end
  assign o_ready = (r.st == PNB_H_IDLE);
  assign o_done = r.done;
  assign o_rdata = r.rdata;
endmodule

// File: tb/pnb_bus_props.sv
// Checker for the pins between the flash host and the flash device
`timescale 1ns/1ps
module pnb_bus_props (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic select_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe,
  input wire logic wait_oe,
  input wire logic wait_out,
  input wire logic double_density,
  input wire logic die_select_bit
);
  // ========
  // Shared timing
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // Two quiet samples, though the device enable drops in the same cycle as the pin
  sequence s_desel;
    select_n ##1 select_n;
  endsequence
  sequence s_oe_off;
    out_en_n ##1 out_en_n;
  endsequence
  // Read strobe opens on a selected die
  sequence s_rd_open;
    !select_n && write_n && $fell(out_en_n) &&
      !(double_density && die_select_bit);
  endsequence
  // Address points at the die this device does not hold
  sequence s_upper_die;
    double_density && die_select_bit;
  endsequence
  // ========
  // Output drivers
  a_desel_data: assert property (s_desel |-> !dq_dev_oe)
    else $error("data driven while deselected");
  a_desel_wait: assert property (s_desel |-> !wait_oe)
    else $error("wait driven while deselected");
  a_oe_data: assert property (s_oe_off |-> !dq_dev_oe)
    else $error("data driven with output enable high");
  a_oe_wait: assert property (s_oe_off |-> !wait_oe)
    else $error("wait driven with output enable high");
  a_read_drive: assert property (s_rd_open |-> ##[0:1] dq_dev_oe)
    else $error("read cycle not driven");
  a_die_float: assert property (s_upper_die |-> !dq_dev_oe)
    else $error("upper die address drove the data bus");
  // Only async reads happen here, so wait stays at its low level
  a_wait_idle: assert property (wait_oe |-> !wait_out)
    else $error("wait asserted in async mode");
  // ========
  // Bus ownership
  a_no_contend: assert property (!(dq_host_oe && dq_dev_oe))
    else $error("both ends drive data");
  a_no_mix: assert property (!(!out_en_n && !write_n))
    else $error("read and write strobes together");
  a_strobe_first: assert property ($rose(select_n) |-> out_en_n && write_n)
    else $error("select released before strobes");
endmodule

// File: tb/test_parallel_nor_bus_signal_interface.sv
// Self-checking bench joining the flash host to the flash device
`timescale 1ns/1ps
`include "pnb_defines.svh"
module test_parallel_nor_bus_signal_interface
  import pnb_pkg::*;
;
  // ========
  // Stimulus and observed signals
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_wr = 1'b0;
  logic [25:1] i_addr = '0;
  logic [15:0] i_wdata = '0;
  logic i_protect_n = 1'b1; // Lock-down override on
  logic i_lockout = 1'b0; // Supply valid
  logic i_double_density = 1'b0; // One die strapped
  logic o_ready;
  logic o_done;
  logic o_busy;
  logic [15:0] o_rdata;
  logic [15:0] o_status;
  integer miscompares = 0;
  integer check_count = 0;
  integer seed = 32'h47bfc255;
  integer mem [0:255]; // Reference array
  integer i;
  integer a;
  logic [15:0] d;
  // Clock at 25 MHz
  always #20 i_mclk = ~i_mclk;
  // ========
  // Both ends and the checker
  pnb_if bus_link();
  pnb_host pnb_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus_link),
    .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_protect_n(i_protect_n), .i_lockout(i_lockout),
    .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata));
  pnb_device pnb_device_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .bus(bus_link), .i_double_density(i_double_density), .o_busy(o_busy),
    .o_status(o_status));
  pnb_bus_props pnb_bus_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .select_n(bus_link.select_n), .out_en_n(bus_link.out_en_n),
    .write_n(bus_link.write_n), .dq_host_oe(bus_link.dq_host_oe),
    .dq_dev_oe(bus_link.dq_dev_oe), .wait_oe(bus_link.wait_oe),
    .wait_out(bus_link.wait_out), .double_density(i_double_density),
    .die_select_bit(bus_link.addr[25]));
  // ========
  // Verdict, reached from the main sequence or the watchdog
  task complete_run;
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Counted compare with its own message
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // One user access; request held until the ready edge takes it
  task acc(input logic w, input logic [25:1] ad, input logic [15:0] wd);
    integer n;
    n = 0;
    @(negedge i_mclk);
    while (o_ready !== 1'b1 && n < 50)
    begin
      @(negedge i_mclk);
      n++;
    end
    i_req = 1'b1;
    i_wr = w;
    i_addr = ad;
    i_wdata = wd;
    @(negedge i_mclk);
    i_req = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 50)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk("done", 16'h0001, {15'h0000, o_done});
  endtask
  // Two-word command, then wait out the automation (bounded)
  task cmd2(input logic [25:1] ad, input logic [15:0] c, input logic [15:0] v);
    integer n;
    acc(1'b1, ad, c);
    acc(1'b1, ad, v);
    n = 0;
    repeat (2) @(negedge i_mclk);
    while (o_busy !== 1'b0 && n < 5000)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk("busy", 16'h0000, {15'h0000, o_busy});
  endtask
  // Array read through the pins against the model
  task rd(input logic [25:1] ad, input integer e);
    acc(1'b1, ad, 16'h00ff);
    acc(1'b0, ad, 16'h0000);
    chk("rdata", e[15:0], o_rdata);
  endtask
  // ========
  // Watchdog sized well past the expected run
  initial
  begin
    repeat (90000) @(posedge i_mclk);
    miscompares++;
    complete_run;
  end
  // ========
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    // Open block zero and erase it
    cmd2(25'h0, 16'h0060, 16'h00d0);
    cmd2(25'h0, 16'h0020, 16'h00d0);
    for (a = 0; a < 256; a++)
      mem[a] = 32'hffff;
    // Random programs with read-back, also through the die bit
    for (i = 0; i < 4; i++)
    begin
      a = i * 16 + ($random(seed) & 15);
      d = $random(seed);
      cmd2(a[25:1], 16'h0040, d);
      mem[a] = mem[a] & d;
      rd(a[25:1], mem[a]);
      rd(a[25:1] | 25'h1000000, mem[a]);
    end
    // Two dies strapped: the upper die leaves the bus at its pull-up
    i_double_density = 1'b1;
    rd(a[25:1] | 25'h1000000, 32'hffff);
    rd(a[25:1], mem[a]);
    i_double_density = 1'b0;
    // Status word read back on the data bus
    acc(1'b1, 25'h0, 16'h0070);
    acc(1'b0, 25'h0, 16'h0000);
    chk("status", `PNB_STATUS_READY, o_rdata);
    // Program under supply lockout leaves the array alone
    i_lockout = 1'b1;
    cmd2(25'h0a0, 16'h0040, 16'h0000);
    chk("vpp", `PNB_STATUS_VPP_ERR, o_status & 16'h0008);
    acc(1'b1, 25'h0, 16'h0050);
    chk("clear", 16'h0000, o_status & 16'h000a);
    i_lockout = 1'b0;
    rd(25'h0a0, mem[8'ha0]);
    // Locked block refuses a program
    cmd2(25'h1c0, 16'h0040, 16'h1234);
    chk("lock", `PNB_STATUS_LOCK_ERR, o_status & 16'h0002);
    acc(1'b1, 25'h0, 16'h0050);
    // Lock-down holds while protect is low
    i_protect_n = 1'b0;
    cmd2(25'h2f0, 16'h0060, 16'h002f);
    cmd2(25'h2f0, 16'h0060, 16'h00d0);
    cmd2(25'h2f0, 16'h0040, 16'h0000);
    chk("ldown", `PNB_STATUS_LOCK_ERR, o_status & 16'h0002);
    acc(1'b1, 25'h0, 16'h0050);
    rd(25'h2f0, mem[8'hf0]);
    // Protect high overrides lock-down
    i_protect_n = 1'b1;
    cmd2(25'h2f0, 16'h0060, 16'h00d0);
    cmd2(25'h2f0, 16'h0040, 16'h5a5a);
    mem[8'hf0] = mem[8'hf0] & 32'h5a5a;
    chk("ovr", 16'h0000, o_status & 16'h000a);
    rd(25'h2f0, mem[8'hf0]);
    complete_run;
  end
endmodule
